//--- design/mb_skip_direct_convert.sv
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/1ps

// Function
// - final pattern bit zero where input zero
// - P slice: only P skip or 16x16 L0 may skip
// - P forced skip, permitted: skip, pattern zero
// - P forced skip, not permitted: type 0
// - P 16x16 skip conditions met: skip flag
// - P skip conditions, not permitted: type 0
// - skip off = slice or per-mb disable
// - B slice: no vector-predictor check
// - B forced skip, permitted: skip, pattern zero
// - B forced skip, not permitted: direct type 0
// - B direct, zero pattern, permitted: skip
// - B direct, zero, not permitted: type 0
// - B direct, skip off: type 0
// - B direct, nonzero pattern: type 0
// - B direct, direct off: type 16h
// - no MBAFF: pair skip always permitted
// - MBAFF first of pair: permitted
// - MBAFF second: field mismatch and first skipped
// - skip predictor zero on missing/zero neighbour
module mb_skip_direct_convert
  import mb_convert_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  // address bus slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // macroblock record
  input wire logic mb_valid,
  input wire logic [2:0] mb_request,
  input wire logic per_mb_skip_conversion_off,
  input wire logic [5:0] coded_block_pattern,
  input wire logic [5:0] quant_pattern,
  input wire logic [15:0] mv_x,
  input wire logic [15:0] mv_y,
  input wire logic nbr_a_avail,
  input wire logic nbr_a_ref_zero,
  input wire logic [15:0] nbr_a_mv_x,
  input wire logic [15:0] nbr_a_mv_y,
  input wire logic nbr_b_avail,
  input wire logic nbr_b_ref_zero,
  input wire logic [15:0] nbr_b_mv_x,
  input wire logic [15:0] nbr_b_mv_y,
  input wire logic [15:0] pred_mv_x,
  input wire logic [15:0] pred_mv_y,
  input wire logic pair_second,
  input wire logic pair_field_flag,
  input wire logic pair_a_avail,
  input wire logic pair_a_field,
  input wire logic pair_b_avail,
  input wire logic pair_b_field,
  // decision toward entropy coding
  output logic out_valid,
  output logic skip_hint_flag,
  output logic [4:0] mb_type,
  output logic [5:0] final_pattern
);

  // ==========================================================================
  // bus slave
  logic [31:0] control_reg;
  logic [31:0] count_reg;
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  logic last_skip_reg;
  logic bus_take;

  assign bus_take = hsel && hready && htrans == HTRANS_NONSEQ;

  // capture address phase
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= bus_take && hwrite;
      if (bus_take)
        addr_reg <= haddr;
    end
  end

  // control register write in data phase
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      control_reg <= CONTROL_RESET;
    else if (wr_pend_reg && addr_reg == ADDR_CONTROL)
      control_reg <= hwdata;
  end

  // read data, registered; zero-wait answer
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      hrdata <= 32'h0000_0000;
    else if (bus_take && !hwrite)
    begin
      unique case (haddr)
        ADDR_CONTROL: hrdata <= control_reg;
        ADDR_STATUS: hrdata <= {26'h0000000, last_skip_reg, mb_type};
        ADDR_COUNT: hrdata <= count_reg;
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // bus answers with no wait state and always okay once out of reset
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ==========================================================================
  // decision logic
  logic slice_b;
  logic mbaff_on;
  logic skip_off;
  logic direct_off;
  logic pair_skip_permitted;
  logic first_skipped_reg;
  logic field_mismatch;
  logic [5:0] pattern_q;
  logic mv_match;
  logic [15:0] skip_pred_x;
  logic [15:0] skip_pred_y;
  logic dec_skip;
  logic [4:0] dec_type;
  logic [5:0] dec_pattern;

  assign slice_b = control_reg[CTRL_SLICE_LSB +: 2] == SLICE_B;
  assign mbaff_on = control_reg[CTRL_MBAFF_BIT];
  assign skip_off = control_reg[CTRL_SKIP_OFF_BIT] | per_mb_skip_conversion_off;
  assign direct_off = control_reg[CTRL_DIRECT_OFF_BIT];
  assign pattern_q = quant_pattern & coded_block_pattern;

  // a vector is zero when both of its components are zero
  function automatic logic vec_is_zero(input logic [15:0] vx, input logic [15:0] vy);
    return vx == 16'h0000 && vy == 16'h0000;
  endfunction

  // skip predictor: zero when a neighbour is missing or still at ref 0 / mv 0
  always_comb
  begin
    if (!nbr_a_avail || !nbr_b_avail ||
        (nbr_a_ref_zero && vec_is_zero(nbr_a_mv_x, nbr_a_mv_y)) ||
        (nbr_b_ref_zero && vec_is_zero(nbr_b_mv_x, nbr_b_mv_y)))
    begin
      skip_pred_x = 16'h0000;
      skip_pred_y = 16'h0000;
    end
    else
    begin
      skip_pred_x = pred_mv_x;
      skip_pred_y = pred_mv_y;
    end
  end
  assign mv_match = mv_x == skip_pred_x && mv_y == skip_pred_y;

  // neighbour pair field comparison, A first then B
  always_comb
  begin
    if (pair_a_avail)
      field_mismatch = pair_field_flag != pair_a_field;
    else if (pair_b_avail)
      field_mismatch = pair_field_flag != pair_b_field;
    else
      field_mismatch = pair_field_flag != 1'b0;
  end

  // pair skip permission
  always_comb
  begin
    if (!mbaff_on)
      pair_skip_permitted = 1'b1;
    else if (!pair_second)
      pair_skip_permitted = 1'b1;
    else
      pair_skip_permitted = !(field_mismatch && first_skipped_reg);
  end

  // conversion table
  always_comb
  begin
    dec_skip = 1'b0;
    dec_type = TYPE_16X16_OR_DIRECT;
    dec_pattern = pattern_q;
    if (!slice_b)
    begin
      // only P skip or 16x16 L0 may reach skip
      if (mb_request == REQ_P_SKIP)
      begin
        dec_pattern = PATTERN_ZERO;
        dec_skip = pair_skip_permitted;
      end
      else if (mb_request == REQ_P_L0_16X16)
        dec_skip = !skip_off && pattern_q == PATTERN_ZERO && mv_match &&
                   pair_skip_permitted;
    end
    else
    begin
      // no vector check in B slices
      if (mb_request == REQ_B_SKIP)
      begin
        dec_pattern = PATTERN_ZERO;
        dec_skip = pair_skip_permitted;
      end
      else if (mb_request == REQ_B_DIRECT)
      begin
        if (direct_off)
          dec_type = TYPE_B_8X8;
        else
          dec_skip = !skip_off && pattern_q == PATTERN_ZERO &&
                     pair_skip_permitted;
      end
    end
  end

  // one registered decision per record
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      out_valid <= 1'b0;
      skip_hint_flag <= 1'b0;
      mb_type <= TYPE_16X16_OR_DIRECT;
      final_pattern <= PATTERN_ZERO;
    end
    else
    begin
      out_valid <= mb_valid;
      if (mb_valid)
      begin
        skip_hint_flag <= dec_skip;
        mb_type <= dec_skip ? TYPE_16X16_OR_DIRECT : dec_type;
        final_pattern <= dec_pattern;
      end
    end
  end

  // first-of-pair skip memory and status
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      first_skipped_reg <= 1'b0;
      last_skip_reg <= 1'b0;
      count_reg <= 32'h0000_0000;
    end
    else if (mb_valid)
    begin
      if (!pair_second)
        first_skipped_reg <= dec_skip;
      last_skip_reg <= dec_skip;
      count_reg <= count_reg + 32'h0000_0001;
    end
  end

  // ==========================================================================
  // checks
  chk_p_forced_skip: assert property (@(posedge clk) disable iff (sys_rst)
    mb_valid && !slice_b && mb_request == REQ_P_SKIP |=>
      final_pattern == PATTERN_ZERO && mb_type == TYPE_16X16_OR_DIRECT)
    else $error("forced p skip not cleared");

  chk_p_forced_flag: assert property (@(posedge clk) disable iff (sys_rst)
    mb_valid && !slice_b && mb_request == REQ_P_SKIP |=>
      skip_hint_flag == $past(pair_skip_permitted))
    else $error("forced p skip flag wrong");

  chk_p_only_16x16: assert property (@(posedge clk) disable iff (sys_rst)
    mb_valid && !slice_b && mb_request != REQ_P_SKIP && mb_request != REQ_P_L0_16X16
      |=> !skip_hint_flag)
    else $error("p macroblock skipped from a wrong type");

  chk_p_convert: assert property (@(posedge clk) disable iff (sys_rst)
    mb_valid && !slice_b && mb_request == REQ_P_L0_16X16 && !skip_off && mv_match &&
      (quant_pattern & coded_block_pattern) == PATTERN_ZERO && pair_skip_permitted
      |=> skip_hint_flag)
    else $error("p 16x16 not converted to skip");

  chk_p_not_permitted: assert property (@(posedge clk) disable iff (sys_rst)
    mb_valid && !slice_b && mb_request == REQ_P_L0_16X16 && !pair_skip_permitted
      |=> !skip_hint_flag && mb_type == TYPE_16X16_OR_DIRECT)
    else $error("p 16x16 skipped while pair skip blocked");

  chk_pattern_mask: assert property (@(posedge clk) disable iff (sys_rst)
    mb_valid |=> (final_pattern & ~$past(coded_block_pattern)) == 6'h00)
    else $error("pattern bit set where input zero");

  chk_skip_off: assert property (@(posedge clk) disable iff (sys_rst)
    mb_valid && per_mb_skip_conversion_off && mb_request == REQ_P_L0_16X16
      |=> !skip_hint_flag)
    else $error("skip despite disable");

  chk_slice_skip_off: assert property (@(posedge clk) disable iff (sys_rst)
    mb_valid && control_reg[CTRL_SKIP_OFF_BIT] && mb_request == REQ_P_L0_16X16
      |=> !skip_hint_flag)
    else $error("skip despite slice disable");

  chk_b_forced: assert property (@(posedge clk) disable iff (sys_rst)
    mb_valid && slice_b && mb_request == REQ_B_SKIP |=>
      final_pattern == PATTERN_ZERO && mb_type == TYPE_16X16_OR_DIRECT &&
      skip_hint_flag == $past(pair_skip_permitted))
    else $error("forced b skip wrong");

  chk_b_direct_skip: assert property (@(posedge clk) disable iff (sys_rst)
    mb_valid && slice_b && mb_request == REQ_B_DIRECT && !direct_off && !skip_off &&
      (quant_pattern & coded_block_pattern) == PATTERN_ZERO |=>
      skip_hint_flag == $past(pair_skip_permitted) && mb_type == TYPE_16X16_OR_DIRECT)
    else $error("b direct not converted as permitted");

  chk_b_skip_off: assert property (@(posedge clk) disable iff (sys_rst)
    mb_valid && slice_b && mb_request == REQ_B_DIRECT && !direct_off && skip_off
      |=> !skip_hint_flag && mb_type == TYPE_16X16_OR_DIRECT)
    else $error("b direct skipped despite disable");

  chk_direct_off: assert property (@(posedge clk) disable iff (sys_rst)
    mb_valid && slice_b && direct_off && mb_request == REQ_B_DIRECT
      |=> mb_type == TYPE_B_8X8 && !skip_hint_flag)
    else $error("direct off not coded as b 8x8");

  chk_direct_nz: assert property (@(posedge clk) disable iff (sys_rst)
    mb_valid && slice_b && !direct_off && mb_request == REQ_B_DIRECT &&
      pattern_q != PATTERN_ZERO |=> !skip_hint_flag && mb_type == 5'h00)
    else $error("nonzero direct skipped");

  chk_no_mbaff: assert property (@(posedge clk) disable iff (sys_rst)
    !mbaff_on |-> pair_skip_permitted)
    else $error("pair skip blocked outside mbaff");

  chk_pair_first: assert property (@(posedge clk) disable iff (sys_rst)
    mbaff_on && !pair_second |-> pair_skip_permitted)
    else $error("first of pair blocked");

  // second of a pair whose first went out skipped, field flags disagreeing
  sequence pair_second_blocked;
    mb_valid && mbaff_on && pair_second && field_mismatch && skip_hint_flag;
  endsequence

  // that second goes out coded, not skipped
  sequence second_coded;
    !skip_hint_flag;
  endsequence

  chk_pair_block: assert property (@(posedge clk) disable iff (sys_rst)
    pair_second_blocked |=> second_coded)
    else $error("second of pair may skip");

  chk_skip_pred_zero: assert property (@(posedge clk) disable iff (sys_rst)
    !nbr_a_avail || !nbr_b_avail |->
      skip_pred_x == 16'h0000 && skip_pred_y == 16'h0000)
    else $error("skip predictor not zeroed");

  chk_one_decision: assert property (@(posedge clk) disable iff (sys_rst)
    mb_valid |=> out_valid)
    else $error("decision lost");

endmodule

//--- design/mb_convert_pkg.sv
package mb_convert_pkg;

  // ==========================================================================
  // requested macroblock kinds
  localparam logic [2:0] REQ_OTHER = 3'h0;
  localparam logic [2:0] REQ_P_SKIP = 3'h1;
  localparam logic [2:0] REQ_P_L0_16X16 = 3'h2;
  localparam logic [2:0] REQ_B_SKIP = 3'h3;
  localparam logic [2:0] REQ_B_DIRECT = 3'h4;

  // ==========================================================================
  // slice kinds
  localparam logic [1:0] SLICE_P = 2'h0;
  localparam logic [1:0] SLICE_B = 2'h1;

  // ==========================================================================
  // coded symbol values
  localparam logic [4:0] TYPE_16X16_OR_DIRECT = 5'h00;
  localparam logic [4:0] TYPE_B_8X8 = 5'h16;
  localparam logic [5:0] PATTERN_ZERO = 6'h00;

  // ==========================================================================
  // address bus map (byte addresses)
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam int CTRL_SKIP_OFF_BIT = 0;
  localparam int CTRL_DIRECT_OFF_BIT = 1;
  localparam int CTRL_MBAFF_BIT = 2;
  localparam int CTRL_SLICE_LSB = 4;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

//--- verification/mb_sink_model.sv
`timescale 1ns/1ps

// ============================================================
// entropy coder model: takes every decision handed to it
module mb_sink_model
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic out_valid,
  input wire logic skip_hint_flag,
  input wire logic [4:0] mb_type,
  input wire logic [5:0] final_pattern,
  output logic [11:0] got_symbols,
  output logic [15:0] got_count
);
  // latch each decision and count them, one per macroblock
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      got_symbols <= 12'h000;
      got_count <= 16'h0000;
    end
    else if (out_valid)
    begin
      got_symbols <= {skip_hint_flag, mb_type, final_pattern};
      got_count <= got_count + 16'h0001;
    end
  end
endmodule

//--- verification/testbench.sv
`timescale 1ns/1ps

// ============================================================
// conversion decisions driven record by record
module testbench
  import mb_convert_pkg::*;
;
  logic clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp, mb_valid, out_valid;
  logic per_mb_skip_conversion_off, nb_avail, pair_second, pair_field_flag, pair_a_avail;
  logic nb_ref_zero, pair_a_field, pair_b_avail, pair_b_field;
  logic skip_hint_flag;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, rd;
  logic [2:0] mb_request;
  logic [4:0] mb_type;
  logic [5:0] coded_block_pattern, quant_pattern, final_pattern;
  logic [15:0] mv_x, pred_mv_x, got_count;
  logic [11:0] got_symbols;
  int bad_count, checks_done, n;

  assign hready = hreadyout;

  mb_skip_direct_convert u_dut (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp, .mb_valid, .mb_request,
    .per_mb_skip_conversion_off, .coded_block_pattern, .quant_pattern, .mv_x,
    .mv_y(16'h0000), .nbr_a_avail(nb_avail), .nbr_a_ref_zero(nb_ref_zero), .nbr_a_mv_x(mv_x),
    .nbr_a_mv_y(16'h0000), .nbr_b_avail(nb_avail), .nbr_b_ref_zero(nb_ref_zero),
    .nbr_b_mv_x(pred_mv_x), .nbr_b_mv_y(16'h0000), .pred_mv_x, .pred_mv_y(16'h0000),
    .pair_second, .pair_field_flag, .pair_a_avail, .pair_a_field,
    .pair_b_avail, .pair_b_field, .out_valid, .skip_hint_flag, .mb_type,
    .final_pattern);

  mb_sink_model u_sink (.clk, .sys_rst, .out_valid, .skip_hint_flag, .mb_type,
    .final_pattern, .got_symbols, .got_count);

  // ============================================================
  // clock, watchdog, checks and verdict
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    #20000;
    bad_count++;
    end_of_test();
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    check({30'h0, hreadyout, hresp}, 32'h2);
  endtask

  // side inputs: {neighbour ref zero, pair A field, pair B available, pair B field}
  task automatic side(input logic [3:0] s);
    @(posedge clk);
    {nb_ref_zero, pair_a_field, pair_b_avail, pair_b_field} <= s;
  endtask

  // one record: fl = {per-mb off, neighbours, second, field, pair A}
  task automatic mb(input logic [2:0] rq, input logic [4:0] fl, input logic [5:0] cb,
    input logic [5:0] q, input logic [15:0] mx, input logic [15:0] px,
    input logic [11:0] ex);
    @(posedge clk);
    mb_valid <= 1'b1;
    mb_request <= rq;
    {per_mb_skip_conversion_off, nb_avail, pair_second, pair_field_flag, pair_a_avail} <= fl;
    coded_block_pattern <= cb;
    quant_pattern <= q;
    mv_x <= mx;
    pred_mv_x <= px;
    @(posedge clk);
    mb_valid <= 1'b0;
    n++;
    @(posedge clk);
    #1;
    check(got_symbols, ex);
    check(got_count, n);
  endtask

  // ============================================================
  // main sequence
  initial
  begin
    {sys_rst, hsel, hwrite, mb_valid, per_mb_skip_conversion_off} = 5'h10;
    {nb_avail, pair_second, pair_field_flag, pair_a_avail} = 4'h0;
    {nb_ref_zero, pair_a_field, pair_b_avail, pair_b_field} = 4'h0;
    {haddr, htrans, hwdata, mb_request} = '0;
    {coded_block_pattern, quant_pattern, mv_x, pred_mv_x} = '0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    bus(1'b0, ADDR_CONTROL, 32'h0);
    check(rd, CONTROL_RESET);
    mb(REQ_P_SKIP, 5'b01000, 6'h3F, 6'h3F, 16'h5, 16'h9, 12'h800);
    mb(REQ_P_SKIP, 5'b01111, 6'h3F, 6'h3F, 16'h5, 16'h9, 12'h800);
    mb(REQ_P_L0_16X16, 5'b01000, 6'h3F, 6'h00, 16'h7, 16'h7, 12'h800);
    mb(REQ_P_L0_16X16, 5'b01000, 6'h0F, 6'h30, 16'h7, 16'h7, 12'h800);
    mb(REQ_P_L0_16X16, 5'b01000, 6'h3F, 6'h21, 16'h7, 16'h7, 12'h021);
    mb(REQ_P_L0_16X16, 5'b01000, 6'h00, 6'h00, 16'h7, 16'h8, 12'h000);
    mb(REQ_P_L0_16X16, 5'b00000, 6'h00, 6'h00, 16'h0, 16'h8, 12'h800);
    side(4'h8);
    mb(REQ_P_L0_16X16, 5'b01000, 6'h00, 6'h00, 16'h0, 16'h8, 12'h800);
    side(4'h0);
    mb(REQ_P_L0_16X16, 5'b11000, 6'h00, 6'h00, 16'h7, 16'h7, 12'h000);
    mb(REQ_OTHER, 5'b01000, 6'h00, 6'h00, 16'h7, 16'h7, 12'h000);
    bus(1'b1, ADDR_CONTROL, 32'h1);
    mb(REQ_P_L0_16X16, 5'b01000, 6'h00, 6'h00, 16'h7, 16'h7, 12'h000);
    mb(REQ_P_SKIP, 5'b01000, 6'h3F, 6'h3F, 16'h5, 16'h9, 12'h800);
    bus(1'b1, ADDR_CONTROL, 32'h10);
    mb(REQ_B_SKIP, 5'b01000, 6'h3F, 6'h3F, 16'h5, 16'h9, 12'h800);
    mb(REQ_B_DIRECT, 5'b01000, 6'h3F, 6'h00, 16'h5, 16'h9, 12'h800);
    mb(REQ_B_DIRECT, 5'b01000, 6'h3F, 6'h04, 16'h5, 16'h5, 12'h004);
    bus(1'b1, ADDR_CONTROL, 32'h11);
    mb(REQ_B_DIRECT, 5'b01000, 6'h3F, 6'h00, 16'h5, 16'h5, 12'h000);
    mb(REQ_B_SKIP, 5'b01000, 6'h3F, 6'h3F, 16'h5, 16'h9, 12'h800);
    bus(1'b1, ADDR_CONTROL, 32'h12);
    mb(REQ_B_DIRECT, 5'b01000, 6'h3F, 6'h00, 16'h5, 16'h5, 12'h580);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check(rd, 32'h16);
    bus(1'b1, ADDR_CONTROL, 32'h14);
    bus(1'b1, 8'h20, 32'hFF);
    bus(1'b0, ADDR_CONTROL, 32'h0);
    check(rd, 32'h14);
    mb(REQ_B_SKIP, 5'b01000, 6'h3F, 6'h3F, 16'h5, 16'h9, 12'h800);
    mb(REQ_B_SKIP, 5'b01111, 6'h3F, 6'h3F, 16'h5, 16'h9, 12'h000);
    mb(REQ_B_DIRECT, 5'b01000, 6'h3F, 6'h04, 16'h5, 16'h5, 12'h004);
    mb(REQ_B_DIRECT, 5'b01111, 6'h3F, 6'h00, 16'h5, 16'h5, 12'h800);
    mb(REQ_B_DIRECT, 5'b01000, 6'h3F, 6'h00, 16'h5, 16'h5, 12'h800);
    mb(REQ_B_DIRECT, 5'b01111, 6'h3F, 6'h00, 16'h5, 16'h5, 12'h000);
    mb(REQ_B_SKIP, 5'b01000, 6'h3F, 6'h3F, 16'h5, 16'h9, 12'h800);
    mb(REQ_B_SKIP, 5'b01101, 6'h3F, 6'h3F, 16'h5, 16'h9, 12'h800);
    side(4'h6);
    mb(REQ_B_SKIP, 5'b01000, 6'h3F, 6'h3F, 16'h5, 16'h9, 12'h800);
    mb(REQ_B_SKIP, 5'b01111, 6'h3F, 6'h3F, 16'h5, 16'h9, 12'h800);
    side(4'h3);
    mb(REQ_B_SKIP, 5'b01000, 6'h3F, 6'h3F, 16'h5, 16'h9, 12'h800);
    mb(REQ_B_SKIP, 5'b01110, 6'h3F, 6'h3F, 16'h5, 16'h9, 12'h800);
    side(4'h0);
    mb(REQ_B_SKIP, 5'b01000, 6'h3F, 6'h3F, 16'h5, 16'h9, 12'h800);
    mb(REQ_B_SKIP, 5'b01110, 6'h3F, 6'h3F, 16'h5, 16'h9, 12'h000);
    bus(1'b1, ADDR_CONTROL, 32'h4);
    mb(REQ_P_SKIP, 5'b01000, 6'h3F, 6'h3F, 16'h5, 16'h9, 12'h800);
    mb(REQ_P_SKIP, 5'b01111, 6'h3F, 6'h3F, 16'h5, 16'h9, 12'h000);
    mb(REQ_P_SKIP, 5'b01000, 6'h3F, 6'h3F, 16'h5, 16'h9, 12'h800);
    mb(REQ_P_L0_16X16, 5'b01111, 6'h3F, 6'h00, 16'h7, 16'h7, 12'h000);
    bus(1'b0, ADDR_COUNT, 32'h0);
    check(rd, n);
    bus(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h0);
    end_of_test();
  end
endmodule
